// File: clock_gate_params.svh
// register offsets, field positions, reset values and write masks of the
// clock gating and pll translation block; definitions only
`ifndef CLOCK_GATE_PARAMS_SVH
`define CLOCK_GATE_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFF_RUN_CLOCK_CONFIG 12'h060
`define OFF_PLL_TRANSLATION 12'h064
`define OFF_RUN_GROUP0 12'h100
`define OFF_RUN_GROUP1 12'h104
`define OFF_RUN_GROUP2 12'h108
`define OFF_SLEEP_GROUP0 12'h110
`define OFF_SLEEP_GROUP1 12'h114
`define OFF_DEEP_GROUP0 12'h120
`define OFF_DEEP_GROUP1 12'h124

// ----------------------------------------------------------------------
// run clock config fields
// ----------------------------------------------------------------------
`define CRYSTAL_LSB 6
`define CRYSTAL_MSB 9
`define CRYSTAL_RESET 4'hb
`define CRYSTAL_FIRST_VALID 4'h4
`define AUTO_GATING_BIT 27
`define RUN_CONFIG_MASK 32'h0800_03c0
`define RUN_CONFIG_RESET 32'h0000_02c0

// ----------------------------------------------------------------------
// pll translation fields and defaults
// ----------------------------------------------------------------------
`define PLL_OUT_DIV_LSB 14
`define PLL_FB_LSB 5
`define PLL_OUT_DIV_DEFAULT 2'h0
`define PLL_FB_DEFAULT 9'h0c8

// ----------------------------------------------------------------------
// gating group 0 and group 1 bit positions
// ----------------------------------------------------------------------
`define G0_PWM_BIT 20
`define G0_WATCHDOG_BIT 3
`define G0_TRACE_BIT 2
`define G0_DEBUG_PORT_BIT 1
`define G0_TEST_PORT_BIT 0
`define G0_MASK 32'h0010_000f
`define G0_RESET 32'h0000_0001
`define G1_COMPARATOR2_BIT 26
`define G1_COMPARATOR1_BIT 25
`define G1_COMPARATOR0_BIT 24
`define G1_TIMER2_BIT 18
`define G1_TIMER1_BIT 17
`define G1_TIMER0_BIT 16
`define G1_SYNC_SERIAL_BIT 4
`define G1_ASYNC1_BIT 1
`define G1_ASYNC0_BIT 0
`define G1_MASK 32'h0707_0013
`define G1_RESET 32'h0000_0000

`endif

// File: clock_gate_pkg.sv
// types shared by the clock gating block: power modes and field carriers
// assumes clock_gate_params.svh holds the numeric constants
package clock_gate_pkg;

    // one-hot power state that picks the active gating set
    typedef enum logic [2:0] {
        MODE_RUN = 3'b001,
        MODE_SLEEP = 3'b010,
        MODE_DEEP = 3'b100
    } power_mode_e;

    // values presented to the pll inputs
    typedef struct packed {
        logic [1:0] pll_output_divider;
        logic [8:0] feedback_mult;
        logic [4:0] ref_divider;
    } pll_translation_s;

    // group 0 clock enables, msb first
    typedef struct packed {
        logic pwm_clock_enable;
        logic watchdog_clock_enable;
        logic trace_output_clock_enable;
        logic debug_port_clock_enable;
        logic test_port_clock_enable;
    } group0_enables_s;

    // group 1 clock enables, msb first
    typedef struct packed {
        logic comparator2_clock_enable;
        logic comparator1_clock_enable;
        logic comparator0_clock_enable;
        logic timer2_clock_enable;
        logic timer1_clock_enable;
        logic timer0_clock_enable;
        logic sync_serial_clock_enable;
        logic async_serial1_clock_enable;
        logic async_serial0_clock_enable;
    } group1_enables_s;

endpackage

// File: clock_gate_ctrl.sv
// apb register block for peripheral clock gating and pll translation
// assumes an apb3 master on core_clk_in and power state inputs from the
// power controller, synchronous to the same clock
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "clock_gate_params.svh"

// Summary of operation
// RL1 - pll translation loads in reset and follows every crystal select change
// RL2 - translation exposes output divider 15:14, multiplier 13:5, reference divider 4:0
// RL3 - gating bit one clocks its unit; zero leaves it unclocked
// RL4 - gating bits reset to zero unless documented otherwise
// RL5 - three gating sets exist: run, sleep and deep sleep
// RL6 - sleep sets apply only with auto clock gating set, else run set
// RL7 - group 0 bit 0 test port clock resets to one; zero stops it
// RL8 - group 0: pwm bit 20, watchdog 3, trace 2, debug port 1
// RL9 - group 1: comparators 2, 1, 0 at bits 26, 25, 24
// RL10 - group 1: timers 2, 1, 0 at bits 18, 17, 16
// RL11 - group 1: sync serial bit 4, async serial 1 bit 1, 0 bit 0
// RL12 - reserved bits are undefined on read; software preserves them
// RL13 - software enables every needed peripheral clock itself
// RL14 - crystal select sits at run config 9:6, resets to 0xb
// RL15 - enables pass a glitch-free gate, changing only while clock is low
// RL16 - active set follows power state on the next clock cycle
module clock_gate_ctrl #(
    parameter int ADDR_W = 12,
    parameter logic [1:0] PLL_OUT_DIV = `PLL_OUT_DIV_DEFAULT,
    parameter logic [8:0] PLL_FB = `PLL_FB_DEFAULT
) (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic sleep_in,
    input wire logic deep_sleep_in,
    output clock_gate_pkg::pll_translation_s pll_translation_out,
    output clock_gate_pkg::group0_enables_s group0_enable_out,
    output clock_gate_pkg::group1_enables_s group1_enable_out,
    output logic [4:0] group0_gclk_out,
    output logic [8:0] group1_gclk_out
);

    // ----------------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------------
    // the highest offset needs nine address bits
    if (ADDR_W < 9 || ADDR_W > 32)
    begin : g_addr_check
        $error("clock_gate_ctrl: ADDR_W must lie in 9..32");
    end

    // ----------------------------------------------------------------------
    // field helpers
    // ----------------------------------------------------------------------
    // translation of crystal code to pll inputs; reserved codes give a zero reference divider
    function automatic clock_gate_pkg::pll_translation_s xlat(input logic [3:0] code);
        clock_gate_pkg::pll_translation_s t;
        t.pll_output_divider = PLL_OUT_DIV;
        t.feedback_mult = PLL_FB;
        t.ref_divider = (code < `CRYSTAL_FIRST_VALID) ? 5'h00 : {1'b0, code};
        return t;
    endfunction

    // group 0 register word to enables
    function automatic clock_gate_pkg::group0_enables_s g0_fields(input logic [31:0] w);
        clock_gate_pkg::group0_enables_s e;
        e.pwm_clock_enable = w[`G0_PWM_BIT];
        e.watchdog_clock_enable = w[`G0_WATCHDOG_BIT];
        e.trace_output_clock_enable = w[`G0_TRACE_BIT];
        e.debug_port_clock_enable = w[`G0_DEBUG_PORT_BIT];
        e.test_port_clock_enable = w[`G0_TEST_PORT_BIT];
        return e;
    endfunction

    // group 1 register word to enables
    function automatic clock_gate_pkg::group1_enables_s g1_fields(input logic [31:0] w);
        clock_gate_pkg::group1_enables_s e;
        e.comparator2_clock_enable = w[`G1_COMPARATOR2_BIT];
        e.comparator1_clock_enable = w[`G1_COMPARATOR1_BIT];
        e.comparator0_clock_enable = w[`G1_COMPARATOR0_BIT];
        e.timer2_clock_enable = w[`G1_TIMER2_BIT];
        e.timer1_clock_enable = w[`G1_TIMER1_BIT];
        e.timer0_clock_enable = w[`G1_TIMER0_BIT];
        e.sync_serial_clock_enable = w[`G1_SYNC_SERIAL_BIT];
        e.async_serial1_clock_enable = w[`G1_ASYNC1_BIT];
        e.async_serial0_clock_enable = w[`G1_ASYNC0_BIT];
        return e;
    endfunction

    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    logic [31:0] run_config_q, run_config_d;
    logic [31:0] g0_q [0:2];
    logic [31:0] g0_d [0:2];
    logic [31:0] g1_q [0:2];
    logic [31:0] g1_d [0:2];
    clock_gate_pkg::pll_translation_s pll_q, pll_d;
    clock_gate_pkg::power_mode_e mode_q, mode_d;
    logic [31:0] prdata_q, prdata_d;
    logic slverr_q, slverr_d;
    clock_gate_pkg::group0_enables_s eff0, en0_neg_q;
    clock_gate_pkg::group1_enables_s eff1, en1_neg_q;
    logic setup_phase, access_wr, hit;
    logic [31:0] rd_word;
    logic [3:0] crystal_q;
    logic auto_gating;

    assign crystal_q = run_config_q[`CRYSTAL_MSB:`CRYSTAL_LSB];
    assign auto_gating = run_config_q[`AUTO_GATING_BIT];
    assign setup_phase = ce_in && psel_in && !penable_in;
    assign access_wr = ce_in && psel_in && penable_in && pwrite_in;

    // ----------------------------------------------------------------------
    // address decode and read mux
    // ----------------------------------------------------------------------
    // reserved and unimplemented bits read as zero; group 2 is not held here
    always_comb
    begin
        hit = 1'b1;
        rd_word = 32'h0000_0000;
        if (paddr_in[1:0] != 2'h0)
            hit = 1'b0;
        else if (paddr_in == ADDR_W'(`OFF_RUN_CLOCK_CONFIG))
            rd_word = run_config_q;
        else if (paddr_in == ADDR_W'(`OFF_PLL_TRANSLATION))
            // RL2 field layout
            rd_word = {16'h0000, pll_q};
        else if (paddr_in == ADDR_W'(`OFF_RUN_GROUP0))
            rd_word = g0_q[0];
        else if (paddr_in == ADDR_W'(`OFF_RUN_GROUP1))
            rd_word = g1_q[0];
        else if (paddr_in == ADDR_W'(`OFF_RUN_GROUP2))
            rd_word = 32'h0000_0000;
        else if (paddr_in == ADDR_W'(`OFF_SLEEP_GROUP0))
            rd_word = g0_q[1];
        else if (paddr_in == ADDR_W'(`OFF_SLEEP_GROUP1))
            rd_word = g1_q[1];
        else if (paddr_in == ADDR_W'(`OFF_DEEP_GROUP0))
            rd_word = g0_q[2];
        else if (paddr_in == ADDR_W'(`OFF_DEEP_GROUP1))
            rd_word = g1_q[2];
        else
            hit = 1'b0;
    end

    // ----------------------------------------------------------------------
    // apb answer
    // ----------------------------------------------------------------------
    // read data and error are captured in the setup cycle so that the
    // access cycle answers from flops with no wait state
    always_comb
    begin
        prdata_d = prdata_q;
        slverr_d = slverr_q;
        if (setup_phase)
        begin
            prdata_d = pwrite_in ? 32'h0000_0000 : rd_word;
            slverr_d = !hit;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end
        else if (ce_in)
        begin
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    assign pready_out = ce_in && psel_in && penable_in;
    assign prdata_out = prdata_q;
    assign pslverr_out = pready_out && slverr_q;

    // ----------------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------------
    // RL12 write masks keep reserved bits at zero whatever software writes
    always_comb
    begin
        run_config_d = run_config_q;
        for (int s = 0; s < 3; s++)
        begin
            g0_d[s] = g0_q[s];
            g1_d[s] = g1_q[s];
        end
        if (access_wr)
        begin
            // RL14 crystal select and auto gating live here
            if (paddr_in == ADDR_W'(`OFF_RUN_CLOCK_CONFIG))
                run_config_d = pwdata_in & `RUN_CONFIG_MASK;
            // RL8 group 0 layout
            else if (paddr_in == ADDR_W'(`OFF_RUN_GROUP0))
                g0_d[0] = pwdata_in & `G0_MASK;
            else if (paddr_in == ADDR_W'(`OFF_SLEEP_GROUP0))
                g0_d[1] = pwdata_in & `G0_MASK;
            else if (paddr_in == ADDR_W'(`OFF_DEEP_GROUP0))
                g0_d[2] = pwdata_in & `G0_MASK;
            // RL9 RL10 RL11 group 1 layout
            else if (paddr_in == ADDR_W'(`OFF_RUN_GROUP1))
                g1_d[0] = pwdata_in & `G1_MASK;
            else if (paddr_in == ADDR_W'(`OFF_SLEEP_GROUP1))
                g1_d[1] = pwdata_in & `G1_MASK;
            else if (paddr_in == ADDR_W'(`OFF_DEEP_GROUP1))
                g1_d[2] = pwdata_in & `G1_MASK;
        end
    end

    // RL4 RL7 reset values of the three sets
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            run_config_q <= `RUN_CONFIG_RESET;
            for (int s = 0; s < 3; s++)
            begin
                g0_q[s] <= `G0_RESET;
                g1_q[s] <= `G1_RESET;
            end
        end
        else if (ce_in)
        begin
            run_config_q <= run_config_d;
            for (int s = 0; s < 3; s++)
            begin
                g0_q[s] <= g0_d[s];
                g1_q[s] <= g1_d[s];
            end
        end
    end

    // ----------------------------------------------------------------------
    // pll translation
    // ----------------------------------------------------------------------
    // RL1 recompute from the held crystal select, one cycle behind a write
    always_comb
    begin
        pll_d = xlat(crystal_q);
    end

    // RL1 loaded during reset from the reset crystal code
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            pll_q <= xlat(`CRYSTAL_RESET);
        else if (ce_in)
            pll_q <= pll_d;
    end

    assign pll_translation_out = pll_q;

    // ----------------------------------------------------------------------
    // power state and active set
    // ----------------------------------------------------------------------
    // RL6 without auto gating the run set governs in every state
    always_comb
    begin
        if (!auto_gating)
            mode_d = clock_gate_pkg::MODE_RUN;
        else if (deep_sleep_in)
            mode_d = clock_gate_pkg::MODE_DEEP;
        else if (sleep_in)
            mode_d = clock_gate_pkg::MODE_SLEEP;
        else
            mode_d = clock_gate_pkg::MODE_RUN;
    end

    // RL16 mode is registered, so the set changes one cycle after the state
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            mode_q <= clock_gate_pkg::MODE_RUN;
        else if (ce_in)
            mode_q <= mode_d;
    end

    // RL5 pick one of the three parallel sets
    always_comb
    begin
        case (mode_q)
            clock_gate_pkg::MODE_SLEEP:
            begin
                eff0 = g0_fields(g0_q[1]);
                eff1 = g1_fields(g1_q[1]);
            end
            clock_gate_pkg::MODE_DEEP:
            begin
                eff0 = g0_fields(g0_q[2]);
                eff1 = g1_fields(g1_q[2]);
            end
            default:
            begin
                eff0 = g0_fields(g0_q[0]);
                eff1 = g1_fields(g1_q[0]);
            end
        endcase
    end

    // ----------------------------------------------------------------------
    // glitch-free clock gates
    // ----------------------------------------------------------------------
    // RL15 enables retimed on the falling edge only change while the clock
    // is low, so the and gate never cuts a high phase short
    always_ff @(negedge core_clk_in)
    begin
        if (srst_in)
        begin
            en0_neg_q <= clock_gate_pkg::group0_enables_s'(5'h01);
            en1_neg_q <= clock_gate_pkg::group1_enables_s'(9'h000);
        end
        else if (ce_in)
        begin
            en0_neg_q <= eff0;
            en1_neg_q <= eff1;
        end
    end

    // RL3 a one passes the clock, a zero holds the unit's clock low
    assign group0_gclk_out = {5{core_clk_in}} & en0_neg_q;
    assign group1_gclk_out = {9{core_clk_in}} & en1_neg_q;
    assign group0_enable_out = en0_neg_q;
    assign group1_enable_out = en1_neg_q;

    // ----------------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);

    pll_follow_a: assert property (ce_in |=> pll_q == xlat($past(crystal_q))) // RL1
    else $error("pll translation does not follow crystal select");

    pll_read_a: assert property ( // RL2
        setup_phase && !pwrite_in && paddr_in == ADDR_W'(`OFF_PLL_TRANSLATION)
        |=> prdata_out == {16'h0000, $past(pll_q)})
    else $error("pll translation read does not match fields");

    reset_state_a: assert property ( // RL4
        $fell(srst_in) |-> g0_q[0] == `G0_RESET && g1_q[0] == `G1_RESET
        && crystal_q == `CRYSTAL_RESET)
    else $error("gating or crystal reset values wrong");

    run_only_a: assert property ( // RL6
        ce_in && !auto_gating |=> mode_q == clock_gate_pkg::MODE_RUN)
    else $error("sleep set used without auto gating");

    deep_select_a: assert property ( // RL16
        ce_in && auto_gating && deep_sleep_in |=> mode_q == clock_gate_pkg::MODE_DEEP)
    else $error("deep sleep set not selected next cycle");

    sleep_set_a: assert property ( // RL5
        mode_q == clock_gate_pkg::MODE_SLEEP |-> eff1 == {g1_q[1][26:24], g1_q[1][18:16],
        g1_q[1][4], g1_q[1][1:0]} && eff0 == {g0_q[1][20], g0_q[1][3:0]})
    else $error("sleep set not applied");

    gate_retime_a: assert property ( // RL15
        ce_in && !$past(srst_in) |-> group0_enable_out == eff0
        && group1_enable_out == eff1)
    else $error("gate enable not retimed from active set");

    write_mask_a: assert property ( // RL11
        access_wr && paddr_in == ADDR_W'(`OFF_RUN_GROUP1)
        |=> g1_q[0] == ($past(pwdata_in) & `G1_MASK))
    else $error("group 1 write mask wrong");

    reserved_zero_a: assert property ( // RL12
        setup_phase && !pwrite_in && paddr_in == ADDR_W'(`OFF_RUN_GROUP0)
        |=> prdata_out[31:21] == 11'h000 && prdata_out[19:4] == 16'h0000)
    else $error("reserved group 0 bits not zero");

    test_port_a: assert property ( // RL7
        access_wr && paddr_in == ADDR_W'(`OFF_RUN_GROUP0) && !pwdata_in[0]
        && !auto_gating |=> ##2 !group0_enable_out.test_port_clock_enable)
    else $error("test port clock not stopped by write of zero");

endmodule

// File: clock_gate_ctrl_tb_top.sv
// self-checking bench for the clock gating and pll translation block
// assumes the block answers apb with zero wait states and no other master
`timescale 1ns/10ps
`include "clock_gate_params.svh"

module clock_gate_ctrl_tb_top;

// ----------------------------------------------------------------------
// signals and design instance
// ----------------------------------------------------------------------
logic core_clk = 0, srst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
logic sleep = 0, deep_sleep = 0, pready, pslverr, err;
logic [11:0] paddr = '0;
logic [31:0] pwdata = '0, prdata, rd, w0, w1, s0, s1, d0, d1;
clock_gate_pkg::pll_translation_s pll;
clock_gate_pkg::group0_enables_s g0_en;
clock_gate_pkg::group1_enables_s g1_en;
logic [4:0] g0_gclk;
logic [8:0] g1_gclk;
int miscompares = 0, check_count = 0;
logic [11:0] offs[6] = '{`OFF_RUN_GROUP0, `OFF_RUN_GROUP1, `OFF_SLEEP_GROUP0,
    `OFF_SLEEP_GROUP1, `OFF_DEEP_GROUP0, `OFF_DEEP_GROUP1};
logic [2:0] mode_tab[6] = '{3'b010, 3'b110, 3'b111, 3'b101, 3'b100, 3'b001};

clock_gate_ctrl DUT (.core_clk_in(core_clk), .srst_in(srst), .ce_in(ce),
    .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .sleep_in(sleep), .deep_sleep_in(deep_sleep),
    .pll_translation_out(pll), .group0_enable_out(g0_en),
    .group1_enable_out(g1_en), .group0_gclk_out(g0_gclk),
    .group1_gclk_out(g1_gclk));

// 100 MHz clock
initial
begin
    forever #5 core_clk = ~core_clk;
end

// ----------------------------------------------------------------------
// expectation functions and checks
// ----------------------------------------------------------------------
function automatic logic [15:0] pll_exp(input logic [3:0] code);
    return {`PLL_OUT_DIV_DEFAULT, `PLL_FB_DEFAULT, 1'b0, (code >= 4'h4) ? code : 4'h0};
endfunction

function automatic logic [4:0] g0_exp(input logic [31:0] w);
    return {w[20], w[3:0]};
endfunction

function automatic logic [8:0] g1_exp(input logic [31:0] w);
    return {w[26:24], w[18:16], w[4], w[1:0]};
endfunction

task automatic check_reg(input logic [31:0] act, input logic [31:0] exp);
    check_count++;
    if (act !== exp)
    begin
        miscompares++;
        $display("unexpected register value at %0t: got %h expected %h", $time, act, exp);
    end
endtask

task automatic check_port(input logic [15:0] act, input logic [15:0] exp);
    check_count++;
    if (act !== exp)
    begin
        miscompares++;
        $display("unexpected port value at %0t: got %h expected %h", $time, act, exp);
    end
endtask

// ----------------------------------------------------------------------
// apb master and helpers
// ----------------------------------------------------------------------
// holds the request until pready is seen high at a rising edge
task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets its answer
    do
    begin
        @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask

task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check_reg(rd, exp);
endtask

// enables land on a falling edge; gated clocks follow the clock high, stay low
task automatic en_chk(input logic [4:0] e0, input logic [8:0] e1);
    @(posedge core_clk);
    #1;
    check_port({11'h000, g0_en}, {11'h000, e0});
    check_port({7'h00, g1_en}, {7'h00, e1});
    check_port({7'h00, g1_gclk, g0_gclk}, {7'h00, e1, e0});
    #5;
    check_port({7'h00, g1_gclk, g0_gclk}, 16'h0000);
endtask

task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask

// watchdog: the tests need well under 5000 cycles
initial
begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    tally_and_finish();
end

// ----------------------------------------------------------------------
// test sequence
// ----------------------------------------------------------------------
initial
begin
    void'($urandom(27));
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    // reset values of every register and of the gating enable and clock outputs
    rd_chk(`OFF_RUN_CLOCK_CONFIG, `RUN_CONFIG_RESET);
    rd_chk(`OFF_PLL_TRANSLATION, {16'h0000, pll_exp(4'hb)});
    for (int i = 0; i < 6; i++)
        rd_chk(offs[i], (i % 2 == 0) ? `G0_RESET : `G1_RESET);
    en_chk(5'h01, 9'h000);
    $display("test reset_values done");

    // every crystal code retranslates the pll fields
    for (int c = 0; c < 16; c++)
    begin
        apb(1'b1, `OFF_RUN_CLOCK_CONFIG, {22'h0, c[3:0], 6'h00});
        rd_chk(`OFF_PLL_TRANSLATION, {16'h0000, pll_exp(c[3:0])});
        check_port(pll, pll_exp(c[3:0]));
    end
    $display("test crystal_translation done");

    // run set: all ones, all zeros, then random words
    for (int i = 0; i < 10; i++)
    begin
        w0 = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0000 : $urandom;
        w1 = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0000 : $urandom;
        apb(1'b1, `OFF_RUN_GROUP0, w0);
        apb(1'b1, `OFF_RUN_GROUP1, w1);
        rd_chk(`OFF_RUN_GROUP0, w0 & `G0_MASK);
        rd_chk(`OFF_RUN_GROUP1, w1 & `G1_MASK);
        en_chk(g0_exp(w0), g1_exp(w1));
    end
    $display("test run_gating done");

    // refused addresses and the unimplemented group
    apb(1'b1, `OFF_RUN_GROUP2, 32'hffff_ffff);
    rd_chk(`OFF_RUN_GROUP2, 32'h0000_0000);
    apb(1'b0, 12'h102, 32'h0000_0000);
    check_port({15'h0000, err}, 16'h0001);
    apb(1'b1, 12'h200, 32'hffff_ffff);
    check_port({15'h0000, err}, 16'h0001);
    rd_chk(`OFF_RUN_GROUP0, w0 & `G0_MASK);
    $display("test refused_access done");

    // sleep and deep sets follow the power state only with auto gating
    s0 = $urandom;
    s1 = $urandom;
    d0 = $urandom;
    d1 = $urandom;
    apb(1'b1, `OFF_SLEEP_GROUP0, s0);
    apb(1'b1, `OFF_SLEEP_GROUP1, s1);
    apb(1'b1, `OFF_DEEP_GROUP0, d0);
    apb(1'b1, `OFF_DEEP_GROUP1, d1);
    for (int i = 0; i < 6; i++)
    begin
        apb(1'b1, `OFF_RUN_CLOCK_CONFIG, {4'h0, mode_tab[i][2], 17'h0, 4'hb, 6'h00});
        sleep <= mode_tab[i][1];
        deep_sleep <= mode_tab[i][0];
        repeat (2) @(posedge core_clk);
        if (mode_tab[i][2] && mode_tab[i][0])
            en_chk(g0_exp(d0), g1_exp(d1));
        else if (mode_tab[i][2] && mode_tab[i][1])
            en_chk(g0_exp(s0), g1_exp(s1));
        else
            en_chk(g0_exp(w0), g1_exp(w1));
    end
    @(posedge core_clk);
    sleep <= 1'b0;
    deep_sleep <= 1'b0;
    $display("test power_modes done");

    // clock enable low in mid-access stalls the answer
    fork
        begin
            repeat (2) @(posedge core_clk);
            ce <= 1'b0;
            repeat (3) @(posedge core_clk);
            // access phase is open but the frozen block must not answer
            check_port({15'h0000, pready}, 16'h0000);
            ce <= 1'b1;
        end
        rd_chk(`OFF_RUN_GROUP1, w1 & `G1_MASK);
    join
    $display("test stalled_access done");

    // second reset in mid-run restores run group 0, sleep group 1, run config and the enables
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd_chk(`OFF_RUN_GROUP0, `G0_RESET);
    rd_chk(`OFF_SLEEP_GROUP1, `G1_RESET);
    rd_chk(`OFF_RUN_CLOCK_CONFIG, `RUN_CONFIG_RESET);
    en_chk(5'h01, 9'h000);
    $display("test second_reset done");
    tally_and_finish();
end

endmodule
